// file: block_xlate_pkg.sv
package block_xlate_pkg;

  // apb address width and register offsets
  localparam int          APB_AW      = 12;
  localparam logic [11:0] ENTRY_BASE  = 12'h000;
  localparam logic [11:0] STATUS_OFF  = 12'h100;
  localparam logic [11:0] MASK_OFF    = 12'h104;
  localparam logic [11:0] DFAULT_OFF  = 12'h108;
  localparam logic [11:0] SRSTAT_OFF  = 12'h10c;
  localparam int          ENTRY_BYTES = 8;

  // entry field positions, little-endian bit numbers
  localparam int BLOCK_EFFECTIVE_INDEX_MSB = 31;
  localparam int BLOCK_EFFECTIVE_INDEX_LSB = 17;
  localparam int BL_MSB   = 12;
  localparam int BL_LSB   = 2;
  localparam int SV_BIT   = 1;
  localparam int UV_BIT   = 0;
  localparam int BLOCK_PHYSICAL_NUMBER_MSB = 31;
  localparam int BLOCK_PHYSICAL_NUMBER_LSB = 17;
  localparam int STORAGE_ATTRIBUTE_BITS_MSB = 6;
  localparam int STORAGE_ATTRIBUTE_BITS_LSB = 3;
  localparam int PP_MSB   = 1;
  localparam int PP_LSB   = 0;

  // writable bits of each entry word; reserved bits stay zero
  localparam logic [31:0] UPPER_WMASK = 32'hfffe1fff;
  localparam logic [31:0] LOWER_WMASK = 32'hfffe007b;

  // protection field encodings
  localparam logic [1:0] PP_NONE = 2'b00;
  localparam logic [1:0] PP_RW   = 2'b10;

  // protection cause bit in both fault cause registers
  localparam int FAULT_PROT_BIT = 27;

  // interrupt status / mask layout
  localparam int INT_W      = 3;
  localparam int INT_DFAULT = 0;
  localparam int INT_IFAULT = 1;
  localparam int INT_PRIV   = 2;

  // reset values
  localparam logic [31:0]      ENTRY_RST  = 32'h0000_0000;
  localparam logic [31:0]      FAULT_RST  = 32'h0000_0000;
  localparam logic [INT_W-1:0] STATUS_RST = 3'h0;
  localparam logic [INT_W-1:0] MASK_RST   = 3'h0;

  // one translation entry: upper and lower words
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
  } entry_t;

  // translation request from fetch or load/store unit
  typedef struct packed {
    logic        valid;
    logic [31:0] ea;
    logic        write;
    logic        touch;
  } xlate_req_t;

  // registered translation answer
  typedef struct packed {
    logic        valid;
    logic        real_mode;
    logic        block_hit;
    logic        to_page;
    logic        fault;
    logic        touch_nop;
    logic [31:0] pa;
    logic [3:0]  storage_attribute_bits;
  } xlate_rsp_t;

  // machine state bits seen by the translator
  typedef struct packed {
    logic user_mode;
    logic instr_translate_enable;
    logic data_translate_enable;
  } machine_state_t;

  // merge write data into an old word under byte strobes and a mask
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb,
                                            input logic [31:0] wmask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r & wmask;
  endfunction

endpackage

// file: entry_store.sv
`timescale 1ns/1ps
module entry_store
  import block_xlate_pkg::*;
#(
  parameter int NUM = 8
)(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   we,
  input  wire logic [$clog2(NUM)-1:0] widx,
  input  wire logic                   wlower,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output entry_t    [NUM-1:0]         ent
);

  // whole array is the module state
  typedef struct packed {
    entry_t [NUM-1:0] ent;
  } store_state_t;

  store_state_t st_r;   // registered array
  store_state_t st_nxt; // next array

  // one word written per access, reserved bits forced to zero
  always_comb
  begin
    st_nxt = st_r;
    if (we)
    begin
      if (wlower)
        st_nxt.ent[widx].lower = strb_merge(st_r.ent[widx].lower, wdata,
                                            wstrb, LOWER_WMASK);
      else
        st_nxt.ent[widx].upper = strb_merge(st_r.ent[widx].upper, wdata,
                                            wstrb, UPPER_WMASK);
    end
  end

  // all entries cleared by reset, so nothing matches until programmed
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM; i++)
      begin
        st_r.ent[i].upper <= ENTRY_RST;
        st_r.ent[i].lower <= ENTRY_RST;
      end
    end
    else
      st_r <= st_nxt;
  end

  // read data straight from the registers
  assign ent = st_r.ent;

endmodule

// file: block_translation_protection.sv
`timescale 1ns/1ps
module block_translation_protection
  import block_xlate_pkg::*;
#(
  parameter int NE = 4  // entries per side: fetch and data
)(
  input  wire logic              clk,
  input  wire logic              nrst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  input  wire logic [2:0]        pprot,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core side
  input  machine_state_t         machine_state_reg,
  input  xlate_req_t             fetch_req,
  input  xlate_req_t             data_req,
  output xlate_rsp_t             fetch_rsp,
  output xlate_rsp_t             data_rsp,
  output logic      [31:0]       data_fault_cause_reg,
  output logic      [31:0]       save_restore_status_one,
  output logic                   irq
);

  localparam int NT = 2 * NE;           // fetch entries low, data high
  localparam int IW = $clog2(NT);       // entry index width
  localparam logic [APB_AW-1:0] ENTRY_END = APB_AW'(NT * ENTRY_BYTES);

  // all module state
  typedef struct packed {
    logic [INT_W-1:0] status;
    logic [INT_W-1:0] mask;
    logic [31:0]      dfault;
    logic [31:0]      srstat;
    logic [31:0]      prdata;
    xlate_rsp_t       irsp;
    xlate_rsp_t       drsp;
  } top_state_t;

  top_state_t        st_r;      // registered state
  top_state_t        st_nxt;    // next state
  entry_t [NT-1:0]   ents;      // whole entry array
  logic              setup;     // apb setup cycle
  logic              access;    // apb access cycle
  logic              in_entry;  // address inside entry region
  logic              mapped;    // address decodes to something
  logic              priv;      // privileged apb access
  logic              ent_we;    // entry write accepted
  logic              priv_err;  // user attempt at entry write
  logic [IW-1:0]     ent_idx;   // entry addressed
  xlate_rsp_t        irsp_c;    // fetch lookup result
  xlate_rsp_t        drsp_c;    // data lookup result

  // does entry qualify for this address in this mode
  function automatic logic entry_match(input entry_t e,
                                       input logic [31:0] ea,
                                       input logic user);
    logic        vld;
    logic [14:0] blx;
    vld = user ? e.upper[UV_BIT] : e.upper[SV_BIT];
    blx = {4'h0, e.upper[BL_MSB:BL_LSB]};
    return vld &&
           ((ea[BLOCK_EFFECTIVE_INDEX_MSB:BLOCK_EFFECTIVE_INDEX_LSB] & ~blx) ==
            e.upper[BLOCK_EFFECTIVE_INDEX_MSB:BLOCK_EFFECTIVE_INDEX_LSB]);
  endfunction

  // protection check on a matching entry
  function automatic logic prot_violation(input logic [1:0] pp,
                                          input logic wr);
    logic v;
    if (pp == PP_NONE)
      v = 1'b1;
    else if (pp[0])
      v = wr;
    else
      v = 1'b0;
    return v;
  endfunction

  // physical address for a hit
  function automatic logic [31:0] phys_addr(input entry_t e,
                                            input logic [31:0] ea);
    logic [31:0] pa;
    logic [10:0] bl;
    bl = e.upper[BL_MSB:BL_LSB];
    pa[31:28] = e.lower[BLOCK_PHYSICAL_NUMBER_MSB -: 4];
    pa[27:17] = e.lower[BLOCK_PHYSICAL_NUMBER_MSB-4:BLOCK_PHYSICAL_NUMBER_LSB] | (ea[27:17] & bl);
    pa[16:0]  = ea[16:0];
    return pa;
  endfunction

  // one side lookup; fetch uses the low half, data the high half
  function automatic xlate_rsp_t lookup(input xlate_req_t q,
                                        input logic fetch,
                                        input machine_state_t ms,
                                        input entry_t [NT-1:0] tab);
    xlate_rsp_t r;
    logic       found;
    logic       en;
    logic       viol;
    entry_t     hit_e;
    r      = '0;
    found  = 1'b0;
    hit_e  = '0;
    viol   = 1'b0;
    r.valid = q.valid;
    en = fetch ? ms.instr_translate_enable : ms.data_translate_enable;
    if (!en)
    begin
      // translation off: real addressing
      r.real_mode = 1'b1;
      r.pa        = q.ea;
    end
    else
    begin
      // lowest matching entry wins if software overlaps blocks
      for (int i = NE - 1; i >= 0; i--)
      begin
        if (entry_match(tab[fetch ? i : i + NE], q.ea, ms.user_mode))
        begin
          found = 1'b1;
          hit_e = tab[fetch ? i : i + NE];
        end
      end
      if (!found)
        r.to_page = 1'b1;
      else
      begin
        // fetches are reads for protection purposes
        viol = prot_violation(hit_e.lower[PP_MSB:PP_LSB],
                              q.write && !fetch);
        r.block_hit = 1'b1;
        r.pa        = phys_addr(hit_e, q.ea);
        r.storage_attribute_bits      = hit_e.lower[STORAGE_ATTRIBUTE_BITS_MSB:STORAGE_ATTRIBUTE_BITS_LSB];
        if (viol && q.touch && !fetch)
          r.touch_nop = 1'b1;
        else
          r.fault = viol;
      end
    end
    if (!q.valid)
      r = '0;
    return r;
  endfunction

  // entry array storage
  entry_store #(
    .NUM (NT)
  ) u_store (
    .clk    (clk),
    .nrst   (nrst),
    .we     (ent_we),
    .widx   (ent_idx),
    .wlower (paddr[2]),
    .wdata  (pwdata),
    .wstrb  (pstrb),
    .ent    (ents)
  );

  // apb decode; zero wait states, so pready is constant high
  always_comb
  begin
    setup    = psel && !penable;
    access   = psel && penable;
    in_entry = (paddr >= ENTRY_BASE) && (paddr < ENTRY_END);
    mapped   = in_entry || (paddr == STATUS_OFF) || (paddr == MASK_OFF) ||
               (paddr == DFAULT_OFF) || (paddr == SRSTAT_OFF);
    priv     = pprot[0];
    ent_idx  = paddr[IW+2:3];
    ent_we   = access && pwrite && in_entry && priv;
    priv_err = access && pwrite && in_entry && !priv;
    pready   = 1'b1;
    // unaligned or unmapped access and user entry writes get pslverr; an unaligned supervisor entry write is still stored
    pslverr  = access && (!mapped || (paddr[1:0] != 2'b00) || priv_err);
    irsp_c   = lookup(fetch_req, 1'b1, machine_state_reg, ents);
    drsp_c   = lookup(data_req, 1'b0, machine_state_reg, ents);
  end

  // next state: registers, sticky events, answers
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.irsp = irsp_c;
    st_nxt.drsp = drsp_c;
    // read data caught in setup so it stands through the access phase
    if (setup)
    begin
      st_nxt.prdata = 32'h0000_0000;
      if (paddr[1:0] != 2'b00)
        st_nxt.prdata = 32'h0000_0000;
      else if (in_entry)
        st_nxt.prdata = paddr[2] ? ents[ent_idx].lower
                                 : ents[ent_idx].upper;
      else if (paddr == STATUS_OFF)
        st_nxt.prdata = {{(32-INT_W){1'b0}}, st_r.status};
      else if (paddr == MASK_OFF)
        st_nxt.prdata = {{(32-INT_W){1'b0}}, st_r.mask};
      else if (paddr == DFAULT_OFF)
        st_nxt.prdata = st_r.dfault;
      else if (paddr == SRSTAT_OFF)
        st_nxt.prdata = st_r.srstat;
    end
    // software writes first; hardware events below override them
    if (access && pwrite && (paddr[1:0] == 2'b00))
    begin
      if (paddr == STATUS_OFF)
        st_nxt.status = st_r.status & ~pwdata[INT_W-1:0]; // write one clear
      else if (paddr == MASK_OFF)
        st_nxt.mask = pwdata[INT_W-1:0];
      else if (paddr == DFAULT_OFF)
        st_nxt.dfault = strb_merge(st_r.dfault, pwdata, pstrb, '1);
      else if (paddr == SRSTAT_OFF)
        st_nxt.srstat = strb_merge(st_r.srstat, pwdata, pstrb, '1);
    end
    // set wins over a clear in the same cycle
    if (drsp_c.fault)
    begin
      st_nxt.dfault[FAULT_PROT_BIT] = 1'b1;
      st_nxt.status[INT_DFAULT]     = 1'b1;
    end
    if (irsp_c.fault)
    begin
      st_nxt.srstat[FAULT_PROT_BIT] = 1'b1;
      st_nxt.status[INT_IFAULT]     = 1'b1;
    end
    if (priv_err)
      st_nxt.status[INT_PRIV] = 1'b1;
  end

  // single state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r.status <= STATUS_RST;
      st_r.mask   <= MASK_RST;
      st_r.dfault <= FAULT_RST;
      st_r.srstat <= FAULT_RST;
      st_r.prdata <= 32'h0000_0000;
      st_r.irsp   <= '0;
      st_r.drsp   <= '0;
    end
    else
      st_r <= st_nxt;
  end

  // outputs from registers
  assign prdata                  = st_r.prdata;
  assign fetch_rsp               = st_r.irsp;
  assign data_rsp                = st_r.drsp;
  assign data_fault_cause_reg    = st_r.dfault;
  assign save_restore_status_one = st_r.srstat;
  // level interrupt while any unmasked sticky bit is set
  assign irq                     = |(st_r.status & st_r.mask);

endmodule

// file: core_unit.sv
`timescale 1ns/1ps
module core_unit
  import block_xlate_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     nrst,
  input  machine_state_t nms,
  input  xlate_req_t    nf,
  input  xlate_req_t    nd,
  output machine_state_t ms,
  output xlate_req_t    f,
  output xlate_req_t    d
);
  // launch after the edge; an idle port shows the inverted old address
  // so a design that ignores valid cannot match a stale request
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ms <= '0;
      f  <= '0;
      d  <= '0;
    end
    else
    begin
      ms <= nms;
      f  <= nf.valid ? nf : xlate_req_t'{1'b0, ~f.ea, 1'b0, 1'b0};
      d  <= nd.valid ? nd : xlate_req_t'{1'b0, ~d.ea, 1'b0, 1'b0};
    end
  end
endmodule

// file: block_xlate_properties.sv
`timescale 1ns/1ps
module block_xlate_properties
  import block_xlate_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [2:0]        pprot,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input machine_state_t         machine_state_reg,
  input xlate_req_t             fetch_req,
  input xlate_req_t             data_req,
  input xlate_rsp_t             fetch_rsp,
  input xlate_rsp_t             data_rsp,
  input wire logic [31:0]       data_fault_cause_reg,
  input wire logic [31:0]       save_restore_status_one,
  input wire logic              irq
);
  // one clock domain for every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_rsp_next: assert property (data_req.valid |=> data_rsp.valid)
    else $error("data answer missing");
  chk_idle_zero: assert property (!fetch_req.valid |=> fetch_rsp == '0)
    else $error("fetch answer without request");
  chk_one_path: assert property (data_rsp.valid |->
    $onehot({data_rsp.real_mode, data_rsp.block_hit, data_rsp.to_page}))
    else $error("data answer path not unique");
  chk_real_data: assert property (data_req.valid &&
    !machine_state_reg.data_translate_enable |=> data_rsp.real_mode &&
    data_rsp.pa == $past(data_req.ea)) else $error("data real mode wrong");
  chk_real_fetch: assert property (fetch_req.valid &&
    !machine_state_reg.instr_translate_enable |=> fetch_rsp.real_mode &&
    fetch_rsp.pa == $past(fetch_req.ea)) else $error("fetch real mode wrong");
  chk_pa_offset: assert property (data_rsp.block_hit |->
    data_rsp.pa[16:0] == $past(data_req.ea[16:0]))
    else $error("block offset not passed");
  chk_dfault_bit: assert property (data_rsp.fault |->
    data_fault_cause_reg[FAULT_PROT_BIT]) else $error("data cause bit clear");
  chk_ifault_bit: assert property (fetch_rsp.fault |->
    save_restore_status_one[FAULT_PROT_BIT]) else $error("fetch bit clear");
  chk_touch_quiet: assert property (data_rsp.touch_nop |->
    !data_rsp.fault && data_rsp.block_hit) else $error("touch hint faulted");
  chk_miss_clean: assert property (data_rsp.to_page |->
    !data_rsp.fault && !data_rsp.touch_nop) else $error("miss was checked");
  chk_user_wr: assert property (psel && penable && pwrite &&
    !pprot[0] && paddr < 12'h040 |-> pslverr)
    else $error("user entry write accepted");

  // main scenarios reached
  cov_hit:   cover property (data_rsp.block_hit);
  cov_fault: cover property (fetch_rsp.fault);
  cov_touch: cover property (data_rsp.touch_nop);
  cov_real:  cover property (data_rsp.real_mode);
endmodule

bind block_translation_protection block_xlate_properties u_chk (.clk, .nrst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot, .prdata, .pready,
  .pslverr, .machine_state_reg, .fetch_req, .data_req, .fetch_rsp, .data_rsp,
  .data_fault_cause_reg, .save_restore_status_one, .irq);

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import block_xlate_pkg::*;
  localparam int NE = 4;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, a, b, c, x = 32'h74f2;
  logic [31:0] data_fault_cause_reg, save_restore_status_one;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] pprot = '0;
  logic pready, pslverr, irq, err;
  machine_state_t nms = '0, machine_state_reg;
  xlate_req_t nf = '0, nd = '0, fetch_req, data_req, r1, r2;
  xlate_rsp_t fetch_rsp, data_rsp, qf[$], qd[$];
  logic [31:0] up [8], lo [8];  // mirror of entry words
  logic [10:0] blt [4] = '{11'h000, 11'h003, 11'h7ff, 11'h07f};
  logic [1:0] vt [8] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h2, 2'h3, 2'h1, 2'h0};
  logic [1:0] ppt [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h1};
  int n_mismatch = 0, total_checks = 0;

  // 100 ns period
  always #50 clk = ~clk;

  core_unit u_core (.clk, .nrst, .nms, .nf, .nd, .ms(machine_state_reg),
    .f(fetch_req), .d(data_req));
  block_translation_protection #(.NE(NE)) DUT (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr,
    .machine_state_reg, .fetch_req, .data_req, .fetch_rsp, .data_rsp,
    .data_fault_cause_reg, .save_restore_status_one, .irq);

  // xorshift, fixed start
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // top nibble 0..3 hits, 4..7 misses; middle bits often zero
  function automatic logic [31:0] mk_ea(input logic [31:0] v);
    return {1'b0, v[30:28], v[27] ? v[26:16] : {7'h0, v[3:0]}, v[16:0]};
  endfunction

  // expected answer from the entry mirror
  function automatic xlate_rsp_t exp_rsp(input logic fe,
    input machine_state_t m, input xlate_req_t r);
    xlate_rsp_t e;
    int k;
    int j;
    logic [10:0] bl;
    logic [1:0] pp;
    e = '0;
    k = -1;
    if (!r.valid)
      return e;
    e.valid = 1'b1;
    if (!(fe ? m.instr_translate_enable : m.data_translate_enable))
    begin
      e.real_mode = 1'b1;
      e.pa = r.ea;
      return e;
    end
    // downward scan so the lowest index wins
    for (int i = NE - 1; i >= 0; i--)
    begin
      j = fe ? i : i + NE;
      bl = up[j][12:2];
      if ((m.user_mode ? up[j][0] : up[j][1]) &&
          (r.ea[31:17] & ~{4'h0, bl}) == up[j][31:17])
        k = j;
    end
    if (k < 0)
    begin
      e.to_page = 1'b1;
      return e;
    end
    bl = up[k][12:2];
    pp = lo[k][1:0];
    e.block_hit = 1'b1;
    e.storage_attribute_bits = lo[k][6:3];
    e.pa = {lo[k][31:28], lo[k][27:17] | (r.ea[27:17] & bl),
            r.ea[16:0]};
    if (pp == PP_NONE || (pp[0] && r.write && !fe))
    begin
      if (r.touch && !fe)
        e.touch_nop = 1'b1;
      else
        e.fault = 1'b1;
    end
    return e;
  endfunction

  // count one comparison, report a mismatch; unknowns fail
  task automatic note(input string n, input logic [63:0] e,
    input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // word compare: register contents and read data
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    note(n, 64'(e), 64'(g));
  endtask

  // single bit compare: error flags, fault bits, interrupt
  task automatic chk_bit(input string n, input logic e, input logic g);
    note(n, 64'(e), 64'(g));
  endtask

  // translation answer compare, whole struct at once
  task automatic chk_rsp(input string n, input xlate_rsp_t e,
    input xlate_rsp_t g);
    note(n, 64'(e), 64'(g));
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; mirror follows accepted supervisor entry writes
  task automatic apb(input logic w, input logic [11:0] ad,
    input logic [31:0] d, input logic pr);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    pprot <= {2'b00, pr};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      finish_test();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && pr && ad < 12'h040)
      begin
        if (ad[2])
          lo[ad[5:3]] = d & LOWER_WMASK;
        else
          up[ad[5:3]] = d & UPPER_WMASK;
      end
      #1;
    end
  endtask

  // one request per port; answer checked two edges later
  task automatic step(input machine_state_t m, input xlate_req_t f,
    input xlate_req_t d);
    @(posedge clk);
    nms <= m;
    nf <= f;
    nd <= d;
    qf.push_back(exp_rsp(1'b1, m, f));
    qd.push_back(exp_rsp(1'b0, m, d));
    #1;
    if (qf.size() == 3)
    begin
      chk_rsp("fetch_rsp", qf.pop_front(), fetch_rsp);
      chk_rsp("data_rsp", qd.pop_front(), data_rsp);
    end
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(0, ENTRY_BASE, 0, 1);
    chk("entry_rst", ENTRY_RST, rd);
    apb(0, MASK_OFF, 0, 1);
    chk("mask_rst", MASK_RST, rd);
    for (int j = 0; j < 8; j++)
    begin
      apb(1, ENTRY_BASE + 12'(8 * j),
          {4'(j % 4), 11'h0, 4'h0, blt[j % 4], vt[j]}, 1);
      apb(1, ENTRY_BASE + 12'(8 * j + 4),
          {4'(15 - j), 11'h155, 10'h0, 4'(3 * j), 1'b0, ppt[j]}, 1);
    end
    apb(0, ENTRY_BASE + 12'h014, 0, 1);
    chk("entry_rdback", lo[2], rd);
    apb(1, ENTRY_BASE, 32'hffff_ffff, 0);
    chk_bit("user_wr_err", 1'b1, err);
    apb(0, ENTRY_BASE, 0, 0);
    chk("entry_kept", up[0], rd);
    apb(0, STATUS_OFF, 0, 1);
    chk_bit("status_priv", 1'b1, rd[INT_PRIV]);
    apb(0, 12'h200, 0, 1);
    chk_bit("unmapped_err", 1'b1, err);
    chk("unmapped_rd", 32'h0000_0000, rd);
    // misaligned word access is refused and reads back zero
    apb(0, STATUS_OFF + 12'h002, 0, 1);
    chk_bit("unaligned_err", 1'b1, err);
    chk("unaligned_rd", 32'h0000_0000, rd);
    // random back-to-back traffic on both ports
    for (int i = 0; i < 800; i++)
    begin
      a = rnd();
      b = rnd();
      c = rnd();
      r1 = '{c[0], mk_ea(a), c[1], 1'b0};
      r2 = '{c[2], mk_ea(b), c[3], c[4] & c[5]};
      step('{c[6], c[11:8] != 0, c[15:12] != 0}, r1, r2);
    end
    repeat (2) step(3'b011, '0, '0);
    // touch hint, then real fault, with interrupt
    apb(1, DFAULT_OFF, 0, 1);
    apb(1, STATUS_OFF, 32'h7, 1);
    apb(1, MASK_OFF, 32'h1, 1);
    chk_bit("irq_idle", 1'b0, irq);
    step(3'b011, '0, '{1'b1, 32'h0000_1234, 1'b1, 1'b1});
    repeat (2) step(3'b011, '0, '0);
    chk("dfault_touch", 0, data_fault_cause_reg);
    chk_bit("irq_touch", 1'b0, irq);
    step(3'b011, '0, '{1'b1, 32'h0000_1234, 1'b1, 1'b0});
    repeat (2) step(3'b011, '0, '0);
    chk_bit("dfault_bit", 1'b1, data_fault_cause_reg[FAULT_PROT_BIT]);
    chk_bit("irq_set", 1'b1, irq);
    apb(1, MASK_OFF, 0, 1);
    chk_bit("irq_masked", 1'b0, irq);
    apb(1, MASK_OFF, 32'h1, 1);
    chk_bit("irq_unmask", 1'b1, irq);
    apb(1, STATUS_OFF, 32'h1, 1);
    chk_bit("irq_clear", 1'b0, irq);
    apb(1, SRSTAT_OFF, 0, 1);
    step(3'b111, '{1'b1, 32'h0000_0040, 1'b0, 1'b0}, '0);
    repeat (2) step(3'b111, '0, '0);
    chk_bit("ifault_bit", 1'b1,
            save_restore_status_one[FAULT_PROT_BIT]);
    finish_test();
  end
endmodule
